/* osh_pkg.sv */
package osh_pkg;

   // Width of the homing method selector
   localparam int METHOD_W = 8;

   // Supported homing method codes
   localparam logic [7:0] METHOD_23 = 8'h17;
   localparam logic [7:0] METHOD_24 = 8'h18;
   localparam logic [7:0] METHOD_25 = 8'h19;
   localparam logic [7:0] METHOD_26 = 8'h1A;
   localparam logic [7:0] METHOD_27 = 8'h1B;
   localparam logic [7:0] METHOD_28 = 8'h1C;
   localparam logic [7:0] METHOD_29 = 8'h1D;

   // Input pins that pass the synchroniser, and their bit positions
   localparam int PIN_COUNT = 3;
   localparam int PIN_ORIGIN = 0;
   localparam int PIN_FWD_LIMIT = 1;
   localparam int PIN_REV_LIMIT = 2;

   // Reset value of the synchroniser flops (switches inactive)
   localparam logic [2:0] PIN_RESET = 3'h0;

   // Sequencer phases, one-hot
   typedef enum logic [3:0] {
      PH_IDLE = 4'h1,
      PH_FAST = 4'h2,
      PH_SLOW = 4'h4,
      PH_BACK = 4'h8
   } osh_phase_t;

endpackage : osh_pkg

/* osh_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser per pin, plus a registered copy for edge detection
module osh_pin_sync (
   input wire logic clk, // Control clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [osh_pkg::PIN_COUNT-1:0] pinIn, // Raw switch pins
   output logic [osh_pkg::PIN_COUNT-1:0] level, // Synchronised level
   output logic [osh_pkg::PIN_COUNT-1:0] rise, // One-cycle rising edge
   output logic [osh_pkg::PIN_COUNT-1:0] fall // One-cycle falling edge
);

   logic [osh_pkg::PIN_COUNT-1:0] meta_r;
   logic [osh_pkg::PIN_COUNT-1:0] sync_r;
   logic [osh_pkg::PIN_COUNT-1:0] prev_r;

   genvar i;
   generate
      for (i = 0; i < osh_pkg::PIN_COUNT; i++) begin : g_pin
         // First flop is read only by the second one
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_r[i] <= osh_pkg::PIN_RESET[i];
               sync_r[i] <= osh_pkg::PIN_RESET[i];
               prev_r[i] <= osh_pkg::PIN_RESET[i];
            end else begin
               meta_r[i] <= pinIn[i];
               sync_r[i] <= meta_r[i];
               prev_r[i] <= sync_r[i];
            end
         end

         // Edges compare the synced level with its registered copy
         assign rise[i] = sync_r[i] & ~prev_r[i];
         assign fall[i] = ~sync_r[i] & prev_r[i];
         assign level[i] = sync_r[i];
      end
   endgenerate

endmodule : osh_pin_sync

`default_nettype wire

/* osh_method_decode.sv */
`timescale 1ns/1ns
`default_nettype none

// Turns a method code into the three traits that drive the sequence
module osh_method_decode (
   input wire logic [7:0] method, // Selected homing method
   output logic supported, // Method is handled here
   output logic searchFwd, // Fast search starts forward
   output logic slowFwd, // Low-speed direction after the rising edge
   output logic stopOnFall // Stop on falling edge, else one more leg
);

   // The second low-speed leg always runs against slowFwd
   always_comb begin
      supported = 1'b1;
      searchFwd = 1'b0;
      slowFwd = 1'b0;
      stopOnFall = 1'b0;
      unique case (method)
         osh_pkg::METHOD_23: begin
            searchFwd = 1'b1;
            stopOnFall = 1'b1;
         end
         osh_pkg::METHOD_24: begin
            searchFwd = 1'b1;
         end
         osh_pkg::METHOD_25: begin
            searchFwd = 1'b1;
            slowFwd = 1'b1;
         end
         osh_pkg::METHOD_26: begin
            searchFwd = 1'b1;
            slowFwd = 1'b1;
            stopOnFall = 1'b1;
         end
         osh_pkg::METHOD_27: begin
            slowFwd = 1'b1;
            stopOnFall = 1'b1;
         end
         osh_pkg::METHOD_28: begin
            slowFwd = 1'b1;
         end
         osh_pkg::METHOD_29: begin
         end
         default: begin
            supported = 1'b0;
         end
      endcase
   end

endmodule : osh_method_decode

`default_nettype wire

/* osh_homing_seq.sv */
// Notes on behaviour
// - Switch active at start: skip fast search, start slow in method's direction.
// - Limit hit in search direction during fast search: reverse, stay fast.
// - 24 no limit: fwd fast, rise to rev slow, fall to fwd slow, stop rise.
// - 24 after limit: rev fast, rise rev slow, fall fwd slow, stop rise.
// - 24 switch active: rev slow, fall to fwd slow, stop on rise.
// - 25 no limit: fwd fast, rise fwd slow, fall rev slow, stop rise.
// - 25 switch active: fwd slow, fall to rev slow, stop on rise.
// - 26 no limit: fwd fast, rise fwd slow, stop on fall.
// - 26 after limit: rise turns to fwd slow, stop on fall.
// - 26 and 27 switch active: fwd slow, stop on fall.
// - 27 no limit: rev fast, rise to fwd slow, stop on fall.
// - 27 after limit: fwd fast, rise fwd slow, stop on fall.
// - 28 no limit: rev fast, rise fwd slow, fall rev slow, stop rise.
// - 28 after limit: fwd fast, rise fwd slow, fall rev slow, stop rise.
// - 28 switch active: fwd slow, fall to rev slow, stop on rise.
// - 29 no limit: rev fast, rise rev slow, fall fwd slow, stop rise.
// - 29 after limit: rise to rev slow, fall fwd slow, stop rise.
// - 29 switch active: rev slow, fall to fwd slow, stop on rise.
`timescale 1ns/1ns
`default_nettype none

module osh_homing_seq (
   input wire logic clk, // Control clock, 250 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic startHoming, // One-cycle request to start homing
   input wire logic abortHoming, // One-cycle request to stop at once
   input wire logic [7:0] homingMethod, // Method selector
   input wire logic originSwitch, // Origin switch pin, active high
   input wire logic fwdLimit, // Forward travel limit pin, active high
   input wire logic revLimit, // Reverse travel limit pin, active high
   output logic moveEnable, // Motion loop should move
   output logic dirForward, // 1 forward, 0 reverse
   output logic speedHigh, // High search speed selected
   output logic speedLow, // Low creep speed selected
   output logic busy, // Sequence in progress
   output logic homingDone, // One-cycle pulse at the final stop
   output logic homingFault, // Sticky fault, cleared by next start
   output logic methodBad // Last start named an unsupported method
);

   logic [osh_pkg::PIN_COUNT-1:0] pinRaw;
   logic [osh_pkg::PIN_COUNT-1:0] pinLevel;
   logic [osh_pkg::PIN_COUNT-1:0] pinRise;
   logic [osh_pkg::PIN_COUNT-1:0] pinFall;
   logic originLevel;
   logic originRise;
   logic originFall;
   logic fwdLimitLevel;
   logic revLimitLevel;

   logic methodOk;
   logic searchFwd;
   logic slowFwd;
   logic stopOnFall;

   osh_pkg::osh_phase_t phase_r;
   osh_pkg::osh_phase_t phase_nxt;
   logic dir_r;
   logic dir_nxt;
   logic reversed_r;
   logic reversed_nxt;
   logic slowFwd_r;
   logic slowFwd_nxt;
   logic stopOnFall_r;
   logic stopOnFall_nxt;
   logic done_r;
   logic done_nxt;
   logic fault_r;
   logic fault_nxt;
   logic bad_r;
   logic bad_nxt;

   logic limitAhead;

   // Pins gathered for the synchroniser
   assign pinRaw[osh_pkg::PIN_ORIGIN] = originSwitch;
   assign pinRaw[osh_pkg::PIN_FWD_LIMIT] = fwdLimit;
   assign pinRaw[osh_pkg::PIN_REV_LIMIT] = revLimit;

   // Every pin passes two flops before the sequencer looks at it
   osh_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pinIn(pinRaw),
      .level(pinLevel),
      .rise(pinRise),
      .fall(pinFall)
   );

   // Origin edges come from the synced, registered copy
   assign originLevel = pinLevel[osh_pkg::PIN_ORIGIN];
   assign originRise = pinRise[osh_pkg::PIN_ORIGIN];
   assign originFall = pinFall[osh_pkg::PIN_ORIGIN];
   assign fwdLimitLevel = pinLevel[osh_pkg::PIN_FWD_LIMIT];
   assign revLimitLevel = pinLevel[osh_pkg::PIN_REV_LIMIT];

   // Method traits are taken at start and held for the whole run
   osh_method_decode u_decode (
      .method(homingMethod),
      .supported(methodOk),
      .searchFwd(searchFwd),
      .slowFwd(slowFwd),
      .stopOnFall(stopOnFall)
   );

   // Limit in the current direction of travel
   assign limitAhead = dir_r ? fwdLimitLevel : revLimitLevel;

   // Phase and direction sequencing
   always_comb begin
      phase_nxt = phase_r;
      dir_nxt = dir_r;
      reversed_nxt = reversed_r;
      slowFwd_nxt = slowFwd_r;
      stopOnFall_nxt = stopOnFall_r;
      done_nxt = 1'b0;
      fault_nxt = fault_r;
      bad_nxt = bad_r;
      unique case (phase_r)
         osh_pkg::PH_IDLE: begin
            if (startHoming) begin
               fault_nxt = 1'b0;
               bad_nxt = ~methodOk;
               if (methodOk) begin
                  slowFwd_nxt = slowFwd;
                  stopOnFall_nxt = stopOnFall;
                  reversed_nxt = 1'b0;
                  if (originLevel) begin
                     // Switch already on: decel point valid, go slow at once
                     phase_nxt = osh_pkg::PH_SLOW;
                     dir_nxt = slowFwd;
                  end else begin
                     phase_nxt = osh_pkg::PH_FAST;
                     dir_nxt = searchFwd;
                  end
               end
            end
         end
         osh_pkg::PH_FAST: begin
            if (abortHoming) begin
               phase_nxt = osh_pkg::PH_IDLE;
            end else if (originRise) begin
               // Decelerate; 23/24/29 end up reverse, the rest forward
               phase_nxt = osh_pkg::PH_SLOW;
               dir_nxt = slowFwd_r;
            end else if (limitAhead) begin
               if (reversed_r) begin
                  // Both limits met without the switch: give up
                  phase_nxt = osh_pkg::PH_IDLE;
                  fault_nxt = 1'b1;
               end else begin
                  dir_nxt = ~dir_r;
                  reversed_nxt = 1'b1;
               end
            end
         end
         osh_pkg::PH_SLOW: begin
            if (abortHoming) begin
               phase_nxt = osh_pkg::PH_IDLE;
            end else if (originFall) begin
               if (stopOnFall_r) begin
                  phase_nxt = osh_pkg::PH_IDLE;
                  done_nxt = 1'b1;
               end else begin
                  // Turn round and creep back onto the switch
                  phase_nxt = osh_pkg::PH_BACK;
                  dir_nxt = ~slowFwd_r;
               end
            end else if (limitAhead) begin
               phase_nxt = osh_pkg::PH_IDLE;
               fault_nxt = 1'b1;
            end
         end
         osh_pkg::PH_BACK: begin
            if (abortHoming) begin
               phase_nxt = osh_pkg::PH_IDLE;
            end else if (originRise) begin
               phase_nxt = osh_pkg::PH_IDLE;
               done_nxt = 1'b1;
            end else if (limitAhead) begin
               phase_nxt = osh_pkg::PH_IDLE;
               fault_nxt = 1'b1;
            end
         end
         default: begin
            // Corrupted one-hot code: fall back to a safe stop
            phase_nxt = osh_pkg::PH_IDLE;
            fault_nxt = 1'b1;
         end
      endcase
   end

   // Sequencer state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_r <= osh_pkg::PH_IDLE;
         dir_r <= 1'b0;
         reversed_r <= 1'b0;
         slowFwd_r <= 1'b0;
         stopOnFall_r <= 1'b0;
         done_r <= 1'b0;
         fault_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         dir_r <= dir_nxt;
         reversed_r <= reversed_nxt;
         slowFwd_r <= slowFwd_nxt;
         stopOnFall_r <= stopOnFall_nxt;
         done_r <= done_nxt;
         fault_r <= fault_nxt;
         bad_r <= bad_nxt;
      end
   end

   // Commands to the motion loop; all decoded from flops only
   assign moveEnable = (phase_r != osh_pkg::PH_IDLE);
   assign busy = (phase_r != osh_pkg::PH_IDLE);
   assign speedHigh = (phase_r == osh_pkg::PH_FAST);
   assign speedLow = (phase_r == osh_pkg::PH_SLOW) || (phase_r == osh_pkg::PH_BACK);
   assign dirForward = dir_r;

   // Status outputs
   assign homingDone = done_r;
   assign homingFault = fault_r;
   assign methodBad = bad_r;

endmodule : osh_homing_seq

`default_nettype wire

/* osh_axis_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Axis with an origin band at 0..40 and travel limits at +-300
module osh_axis_model (
   input wire logic clk, // Control clock
   input wire logic load, // Load the start position
   input wire logic signed [31:0] startPos, // Position to load
   input wire logic moveEnable, // Move request
   input wire logic dirForward, // 1 forward
   input wire logic speedHigh, // Fast speed
   output logic originSwitch, // High inside the band
   output logic fwdLimit, // Forward limit
   output logic revLimit // Reverse limit
);
   int pos = 0;

   // Fast is four units a cycle, so each edge is overshot like a real stop
   always @(posedge clk) begin
      if (load) begin
         pos <= startPos;
      end else if (moveEnable) begin
         pos <= pos + (dirForward ? 1 : -1) * (speedHigh ? 4 : 1);
      end
   end

   // Switch levels follow position only
   assign originSwitch = pos >= 0 && pos <= 40;
   assign fwdLimit = pos >= 300;
   assign revLimit = pos <= -300;
endmodule : osh_axis_model

`default_nettype wire

/* osh_homing_seq_properties.sv */
`timescale 1ns/1ns
`default_nettype none

// Relations between switch edges and motion commands
module osh_homing_seq_checker (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic startHoming, // Start
   input wire logic [7:0] homingMethod, // Method
   input wire logic originSwitch, // Origin pin
   input wire logic fwdLimit, // Forward limit pin
   input wire logic revLimit, // Reverse limit pin
   input wire logic moveEnable, // Moving
   input wire logic dirForward, // Direction
   input wire logic speedHigh, // Fast
   input wire logic speedLow, // Creep
   input wire logic busy, // Busy
   input wire logic homingDone // Done pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Methods that stop on the falling edge
   logic fallStop;
   assign fallStop = homingMethod inside {osh_pkg::METHOD_23, osh_pkg::METHOD_26,
      osh_pkg::METHOD_27};

   // Accepted start; the pin must have settled through the synchroniser first
   sequence s_start;
      startHoming && !busy && homingMethod inside {[osh_pkg::METHOD_23:osh_pkg::METHOD_29]};
   endsequence
   sequence s_pin_high;
      originSwitch [*4];
   endsequence
   sequence s_pin_low;
      (!originSwitch) [*4];
   endsequence

   a_active_start: assert property (s_pin_high ##0 s_start |=> speedLow && !speedHigh)
      else $error("active switch did not start slow");
   a_fast_start: assert property (s_pin_low ##0 s_start |=>
      speedHigh && dirForward == ($past(homingMethod) < osh_pkg::METHOD_27))
      else $error("fast search start wrong");
   a_limit_reverse: assert property (speedHigh && $rose(dirForward ? fwdLimit : revLimit)
      |-> ##[2:5] (speedHigh && $changed(dirForward)))
      else $error("no fast reversal at limit");
   a_rise_slows: assert property (speedHigh && $rose(originSwitch)
      |-> ##[2:5] (speedLow && !speedHigh))
      else $error("rise did not slow down");
   a_fall_turns: assert property (speedLow && $fell(originSwitch) && !fallStop
      |-> ##[2:5] (speedLow && $changed(dirForward)))
      else $error("fall did not turn creep");
   a_stop_fall: assert property (speedLow && $fell(originSwitch) && fallStop
      |-> ##[2:5] homingDone)
      else $error("no stop on falling edge");
   a_stop_rise: assert property (speedLow && $rose(originSwitch) && !fallStop
      |-> ##[2:5] homingDone)
      else $error("no stop on rising edge");
   a_done_at_stop: assert property (homingDone |-> !moveEnable && $past(moveEnable))
      else $error("done without a stop");
   a_done_single: assert property (homingDone |=> !homingDone)
      else $error("done longer than one cycle");
endmodule : osh_homing_seq_checker

bind osh_homing_seq osh_homing_seq_checker u_chk (
   .clk(clk), .rst(rst), .startHoming(startHoming), .homingMethod(homingMethod),
   .originSwitch(originSwitch), .fwdLimit(fwdLimit), .revLimit(revLimit),
   .moveEnable(moveEnable), .dirForward(dirForward), .speedHigh(speedHigh),
   .speedLow(speedLow), .busy(busy), .homingDone(homingDone)
);

`default_nettype wire

/* origin_switch_homing_sequencer_test.sv */
`timescale 1ns/1ns
`default_nettype none

module origin_switch_homing_sequencer_test;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic startHoming = 1'h0;
   logic abortHoming = 1'h0;
   logic [7:0] homingMethod = 8'h18;
   logic load = 1'h0;
   logic signed [31:0] startPos = 32'sh0;
   logic originSwitch, fwdLimit, revLimit, moveEnable, dirForward;
   logic speedHigh, speedLow, busy, homingDone, homingFault, methodBad;
   logic [3:0] vec, lastVec = 4'h0;
   logic [3:0] expQ[$];
   logic [3:0] gotQ[$];
   int fails = 0;
   int comparisons = 0;
   int seed = 68;

   // 250 MHz control clock
   always #2 clk = ~clk;

   osh_homing_seq u_dut (
      .clk(clk), .rst(rst), .startHoming(startHoming), .abortHoming(abortHoming),
      .homingMethod(homingMethod), .originSwitch(originSwitch), .fwdLimit(fwdLimit),
      .revLimit(revLimit), .moveEnable(moveEnable), .dirForward(dirForward),
      .speedHigh(speedHigh), .speedLow(speedLow), .busy(busy), .homingDone(homingDone),
      .homingFault(homingFault), .methodBad(methodBad)
   );

   osh_axis_model u_axis (
      .clk(clk), .load(load), .startPos(startPos), .moveEnable(moveEnable),
      .dirForward(dirForward), .speedHigh(speedHigh), .originSwitch(originSwitch),
      .fwdLimit(fwdLimit), .revLimit(revLimit)
   );

   // Leg recorder on the falling edge, clear of drive and check instants
   assign vec = {moveEnable, moveEnable & dirForward, speedHigh, speedLow};
   always @(negedge clk) begin
      if (vec !== lastVec) begin
         lastVec = vec;
         gotQ.push_back(vec);
      end
   end

   task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // Bench model: legs E/A fast fwd/rev, D/9 slow fwd/rev, 0 stopped
   function automatic void build(input int m, input int c);
      bit sf = m <= 26;
      bit lf = m >= 25 && m <= 28;
      bit sof = m == 23 || m == 26 || m == 27;
      expQ.delete();
      if (c != 2) expQ.push_back(sf ? 4'hE : 4'hA);
      if (c == 1) expQ.push_back(sf ? 4'hA : 4'hE);
      expQ.push_back(lf ? 4'hD : 4'h9);
      if (!sof) expQ.push_back(lf ? 4'h9 : 4'hD);
      expQ.push_back(4'h0);
   endfunction : build

   // Case c: 0 origin ahead, 1 origin behind (limit first), 2 switch active
   task automatic home(input int m, input int c);
      int n = 0;
      int p;
      p = (c == 2) ? 12 : (((m <= 26) ^ (c == 1)) ? -100 : 150);
      load = 1'h1;
      startPos = p + ($random(seed) & 15);
      @(posedge clk) #1;
      load = 1'h0;
      build(m, c);
      repeat (6) @(posedge clk);
      #1;
      gotQ.delete();
      homingMethod = m[7:0];
      startHoming = 1'h1;
      @(posedge clk) #1;
      startHoming = 1'h0;
      while (homingDone !== 1'h1 && n < 3000) begin
         @(posedge clk) #1;
         n++;
      end
      check({3'h0, homingDone}, 4'h1, "done");
      @(negedge clk) #1;
      check(4'(gotQ.size()), 4'(expQ.size()), "legs");
      foreach (expQ[i]) check(gotQ[i], expQ[i], "leg");
      check({3'h0, homingFault}, 4'h0, "fault");
   endtask : home

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // Every method in every start case, then an abort in mid-search
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst = 1'h0;
      repeat (3) @(posedge clk);
      for (int m = 23; m <= 29; m++) begin
         for (int c = 0; c < 3; c++) begin
            home(m, c);
         end
      end
      // Unsupported code: must stay idle and flag it
      homingMethod = 8'h30;
      startHoming = 1'h1;
      @(posedge clk) #1;
      startHoming = 1'h0;
      check({moveEnable, busy, methodBad, homingFault}, 4'h2, "bad method");
      // Abort in the fast search, clear of any switch edge
      load = 1'h1;
      startPos = -32'sd100;
      @(posedge clk) #1;
      load = 1'h0;
      repeat (5) @(posedge clk);
      #1;
      homingMethod = 8'h18;
      startHoming = 1'h1;
      @(posedge clk) #1;
      startHoming = 1'h0;
      check({moveEnable, speedHigh, methodBad, 1'h0}, 4'hC, "fast start");
      repeat (5) @(posedge clk);
      #1;
      abortHoming = 1'h1;
      @(posedge clk) #1;
      abortHoming = 1'h0;
      check({moveEnable, busy, homingDone, homingFault}, 4'h0, "abort");
      stop_test();
   end

   // Watchdog: 21 runs need far fewer than 20000 cycles
   initial begin
      #80000;
      fails++;
      stop_test();
   end
endmodule : origin_switch_homing_sequencer_test

`default_nettype wire
